// ### lpd_pkg.sv
`default_nettype none
package lpd_pkg;
  // ****************************************
  // register map and layout
  // ****************************************
  localparam logic [7:0] ADDR_DRIVE_TYPE = 8'h71;
  localparam logic [7:0] ADDR_LINK       = 8'h72;
  localparam logic [7:0] ADDR_POLARITY   = 8'h73;
  localparam logic [7:0] ADDR_HOST_DRIVE = 8'h74;
  localparam logic [7:0] ADDR_MIRROR     = 8'h79;

  localparam int unsigned CH_N  = 3;
  localparam int unsigned PAD_W = 8 - CH_N;

  localparam logic [CH_N-1:0]  CH_REG_RST = 3'h0;
  localparam logic [PAD_W-1:0] RD_PAD     = 5'h00;
  localparam logic [7:0]       RD_RST     = 8'h00;

  // ****************************************
  // duty and pwm timing
  // ****************************************
  localparam int unsigned PCT_W = 7;
  typedef logic [PCT_W-1:0] lpd_pct_t;

  // one pwm period is 100 steps of one percent each
  localparam lpd_pct_t PWM_LAST = 7'h63;
  localparam lpd_pct_t PCT_ZERO = 7'h00;

  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned PWM_STEP_NS   = 100;
  localparam int unsigned PWM_STEP_CYC  = (PWM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = $clog2(PWM_STEP_CYC);
  typedef logic [DIV_W-1:0] lpd_div_t;
  localparam lpd_div_t DIV_LAST = lpd_div_t'(PWM_STEP_CYC - 1);
  localparam lpd_div_t DIV_ZERO = lpd_div_t'(0);
endpackage : lpd_pkg
`default_nettype wire

// ### lpd_pwm.sv
`default_nettype none
module lpd_pwm (
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire lpd_pkg::lpd_pct_t [lpd_pkg::CH_N-1:0]  duty,
  output var  logic [lpd_pkg::CH_N-1:0]               active
);
  // ****************************************
  // step divider and shared period counter
  // ****************************************
  lpd_pkg::lpd_div_t div_r;
  lpd_pkg::lpd_div_t div_nxt;
  lpd_pkg::lpd_pct_t cnt_r;
  lpd_pkg::lpd_pct_t cnt_nxt;
  logic [lpd_pkg::CH_N-1:0] act_nxt;
  logic step_en;

  always_comb begin
    step_en = (div_r == lpd_pkg::DIV_LAST);
    div_nxt = step_en ? lpd_pkg::DIV_ZERO : div_r + 1'b1;
    cnt_nxt = cnt_r;
    if (step_en) begin
      cnt_nxt = (cnt_r == lpd_pkg::PWM_LAST) ? lpd_pkg::PCT_ZERO : cnt_r + 1'b1;
    end
  end

  // duty above 100 simply saturates at always active
  genvar i;
  generate
    for (i = 0; i < lpd_pkg::CH_N; i++) begin : g_cmp
      always_comb begin
        act_nxt[i] = (cnt_r < duty[i]);
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r  <= lpd_pkg::DIV_ZERO;
      cnt_r  <= lpd_pkg::PCT_ZERO;
      active <= lpd_pkg::CH_REG_RST;
    end else begin
      div_r  <= div_nxt;
      cnt_r  <= cnt_nxt;
      active <= act_nxt;
    end
  end
endmodule // lpd_pwm
`default_nettype wire

// ### lpd_pin_stage.sv
`default_nettype none
module lpd_pin_stage (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [lpd_pkg::CH_N-1:0]      level,
  input  wire logic [lpd_pkg::CH_N-1:0]      push_pull,
  output var  logic [lpd_pkg::CH_N-1:0]      pin_out,
  output var  logic [lpd_pkg::CH_N-1:0]      pin_oe
);
  logic [lpd_pkg::CH_N-1:0] out_nxt;
  logic [lpd_pkg::CH_N-1:0] oe_nxt;

  genvar i;
  generate
    for (i = 0; i < lpd_pkg::CH_N; i++) begin : g_pin
      always_comb begin
        if (push_pull[i]) begin
          out_nxt[i] = level[i];
          oe_nxt[i]  = 1'b1;
        end else begin
          // open drain: only ever sinks, high comes from the pull-up
          out_nxt[i] = 1'b0;
          oe_nxt[i]  = ~level[i];
        end
      end
    end
  endgenerate

  // reset releases every pin: safe for both drive types
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= lpd_pkg::CH_REG_RST;
      pin_oe  <= lpd_pkg::CH_REG_RST;
    end else begin
      pin_out <= out_nxt;
      pin_oe  <= oe_nxt;
    end
  end
endmodule // lpd_pin_stage
`default_nettype wire

// ### lpd_led_pin_drive_control.sv
// Functional notes
// - one bit per channel, channel n at bit n-1
// - open drain sinks low, else high impedance
// - push-pull drives both levels actively
// - five byte registers, three low bits used
// - linked channel actuated by its sensor touch
// - unlinked channel ignores touch, uses host bit
// - linked channel ignores its host drive bit
// - polarity write copies to mirror unless blocked
// - linked touch equals host drive bit one
// - inverted polarity: actuated drives pin low
// - non-inverted: actuated gives logic one level
// - inverted: duty is low time, min idle
// - non-inverted: duty is high time, inverse brightness
// - host bit zero min duty, one actuates
// - non-inverted direct brightness is 100 minus max
// - mirror bits never touch pin drive
// - mirror selects duty relative to 100 or 0
`default_nettype none
module lpd_led_pin_drive_control (
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire logic [7:0]                             reg_addr,
  input  wire logic                                   reg_wr_en,
  input  wire logic [7:0]                             reg_wdata,
  input  wire logic                                   reg_rd_en,
  output var  logic [7:0]                             reg_rdata,
  input  wire logic                                   sense_input_1,
  input  wire logic                                   sense_input_2,
  input  wire logic                                   sense_input_3,
  input  wire logic                                   polarity_mirror_block,
  input  wire lpd_pkg::lpd_pct_t [lpd_pkg::CH_N-1:0]  min_duty,
  input  wire lpd_pkg::lpd_pct_t [lpd_pkg::CH_N-1:0]  max_duty,
  input  wire logic [lpd_pkg::CH_N-1:0]               beh_direct,
  input  wire lpd_pkg::lpd_pct_t [lpd_pkg::CH_N-1:0]  beh_level,
  output var  logic [lpd_pkg::CH_N-1:0]               led_actuated,
  output var  logic [lpd_pkg::CH_N-1:0]               led_duty_mirror,
  output var  logic [lpd_pkg::CH_N-1:0]               led_pin_out,
  output var  logic [lpd_pkg::CH_N-1:0]               led_pin_oe
);
  // ****************************************
  // register file
  // ****************************************
  logic [lpd_pkg::CH_N-1:0] drive_type_r;
  logic [lpd_pkg::CH_N-1:0] drive_type_nxt;
  logic [lpd_pkg::CH_N-1:0] touch_link_r;
  logic [lpd_pkg::CH_N-1:0] touch_link_nxt;
  logic [lpd_pkg::CH_N-1:0] polarity_r;
  logic [lpd_pkg::CH_N-1:0] polarity_nxt;
  logic [lpd_pkg::CH_N-1:0] host_drive_r;
  logic [lpd_pkg::CH_N-1:0] host_drive_nxt;
  logic [lpd_pkg::CH_N-1:0] duty_mirror_r;
  logic [lpd_pkg::CH_N-1:0] duty_mirror_nxt;
  logic [7:0]               rdata_r;
  logic [7:0]               rdata_nxt;
  logic [lpd_pkg::CH_N-1:0] wr_bits;

  always_comb begin
    wr_bits         = reg_wdata[lpd_pkg::CH_N-1:0];
    drive_type_nxt  = drive_type_r;
    touch_link_nxt  = touch_link_r;
    polarity_nxt    = polarity_r;
    host_drive_nxt  = host_drive_r;
    duty_mirror_nxt = duty_mirror_r;
    if (reg_wr_en) begin
      unique case (reg_addr)
        lpd_pkg::ADDR_DRIVE_TYPE: drive_type_nxt = wr_bits;
        lpd_pkg::ADDR_LINK:       touch_link_nxt = wr_bits;
        lpd_pkg::ADDR_POLARITY: begin
          polarity_nxt = wr_bits;
          if (!polarity_mirror_block) begin
            duty_mirror_nxt = wr_bits;
          end
        end
        lpd_pkg::ADDR_HOST_DRIVE: host_drive_nxt  = wr_bits;
        lpd_pkg::ADDR_MIRROR:     duty_mirror_nxt = wr_bits;
        default: begin
        end
      endcase
    end
  end

  // unmapped reads return zero rather than holding stale data
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_en) begin
      unique case (reg_addr)
        lpd_pkg::ADDR_DRIVE_TYPE: rdata_nxt = {lpd_pkg::RD_PAD, drive_type_r};
        lpd_pkg::ADDR_LINK:       rdata_nxt = {lpd_pkg::RD_PAD, touch_link_r};
        lpd_pkg::ADDR_POLARITY:   rdata_nxt = {lpd_pkg::RD_PAD, polarity_r};
        lpd_pkg::ADDR_HOST_DRIVE: rdata_nxt = {lpd_pkg::RD_PAD, host_drive_r};
        lpd_pkg::ADDR_MIRROR:     rdata_nxt = {lpd_pkg::RD_PAD, duty_mirror_r};
        default:                  rdata_nxt = lpd_pkg::RD_RST;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_type_r  <= lpd_pkg::CH_REG_RST;
      touch_link_r  <= lpd_pkg::CH_REG_RST;
      polarity_r    <= lpd_pkg::CH_REG_RST;
      host_drive_r  <= lpd_pkg::CH_REG_RST;
      duty_mirror_r <= lpd_pkg::CH_REG_RST;
      rdata_r       <= lpd_pkg::RD_RST;
    end else begin
      drive_type_r  <= drive_type_nxt;
      touch_link_r  <= touch_link_nxt;
      polarity_r    <= polarity_nxt;
      host_drive_r  <= host_drive_nxt;
      duty_mirror_r <= duty_mirror_nxt;
      rdata_r       <= rdata_nxt;
    end
  end

  assign reg_rdata       = rdata_r;
  // mirror only reaches the behaviour engine, which does the ramp stepping
  assign led_duty_mirror = duty_mirror_r;

  // ****************************************
  // actuation and duty selection
  // ****************************************
  logic [lpd_pkg::CH_N-1:0] touch;
  logic [lpd_pkg::CH_N-1:0] act_r;
  logic [lpd_pkg::CH_N-1:0] act_nxt;
  lpd_pkg::lpd_pct_t [lpd_pkg::CH_N-1:0] duty;
  logic [lpd_pkg::CH_N-1:0] pwm_active;
  logic [lpd_pkg::CH_N-1:0] pin_level;

  assign touch = {sense_input_3, sense_input_2, sense_input_1};

  genvar i;
  generate
    for (i = 0; i < lpd_pkg::CH_N; i++) begin : g_ch
      always_comb begin
        // a touch and a host one are the same request
        act_nxt[i] = touch_link_r[i] ? touch[i] : host_drive_r[i];
      end

      // duty is the share of the period the pin sits at its active level
      always_comb begin
        if (!act_r[i]) begin
          duty[i] = min_duty[i];
        end else if (beh_direct[i]) begin
          duty[i] = max_duty[i];
        end else begin
          duty[i] = beh_level[i];
        end
      end

      always_comb begin
        // inverted active is low, non-inverted active is high
        pin_level[i] = ~(pwm_active[i] ^ polarity_r[i]);
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_r <= lpd_pkg::CH_REG_RST;
    end else begin
      act_r <= act_nxt;
    end
  end

  assign led_actuated = act_r;

  // ****************************************
  // pwm and pin drivers
  // ****************************************
  lpd_pwm u_pwm (
    .clk    (clk),
    .rst    (rst),
    .duty   (duty),
    .active (pwm_active)
  );

  lpd_pin_stage u_pin (
    .clk       (clk),
    .rst       (rst),
    .level     (pin_level),
    .push_pull (drive_type_r),
    .pin_out   (led_pin_out),
    .pin_oe    (led_pin_oe)
  );

  // ****************************************
  // checks
  // ****************************************
  generate
    for (i = 0; i < lpd_pkg::CH_N; i++) begin : g_chk
      a_od_sink_low: assert property (@(posedge clk) disable iff (rst)
        (!drive_type_r[i] && !pin_level[i]) |=> (led_pin_oe[i] && !led_pin_out[i]))
        else $error("open drain did not sink low");
      a_od_release_hiz: assert property (@(posedge clk) disable iff (rst)
        (!drive_type_r[i] && pin_level[i]) |=> !led_pin_oe[i])
        else $error("open drain did not release pin");
      a_pp_follow_level: assert property (@(posedge clk) disable iff (rst)
        drive_type_r[i] |=> (led_pin_oe[i] && (led_pin_out[i] == $past(pin_level[i]))))
        else $error("push pull pin not driven to level");
      a_link_uses_touch: assert property (@(posedge clk) disable iff (rst)
        touch_link_r[i] |=> (act_r[i] == $past(touch[i])))
        else $error("linked channel not following touch");
      a_unlinked_uses_host: assert property (@(posedge clk) disable iff (rst)
        (!touch_link_r[i] && !host_drive_r[i]) |=> !act_r[i])
        else $error("unlinked channel actuated without host bit");
      a_host_ignored: assert property (@(posedge clk) disable iff (rst)
        (touch_link_r[i] && host_drive_r[i] && !touch[i]) |=> !act_r[i])
        else $error("host bit acted on linked channel");
      a_inverted_low: assert property (@(posedge clk) disable iff (rst)
        (pwm_active[i] && !polarity_r[i]) |-> !pin_level[i])
        else $error("inverted active level not low");
      a_idle_min_duty: assert property (@(posedge clk) disable iff (rst)
        !act_r[i] |-> (duty[i] == min_duty[i]))
        else $error("unactuated channel not at min duty");
      a_direct_max_duty: assert property (@(posedge clk) disable iff (rst)
        (act_r[i] && beh_direct[i]) |-> (duty[i] == max_duty[i]))
        else $error("direct actuated channel not at max duty");
      a_inv_pin_low: assert property (@(posedge clk) disable iff (rst)
        (pwm_active[i] && !polarity_r[i]) |=> (led_pin_oe[i] && !led_pin_out[i]))
        else $error("inverted active pin not sunk low");
      a_noninv_pp_high: assert property (@(posedge clk) disable iff (rst)
        (pwm_active[i] && polarity_r[i] && drive_type_r[i])
        |=> (led_pin_oe[i] && led_pin_out[i]))
        else $error("non-inverted push pull pin not high");
      a_noninv_od_hiz: assert property (@(posedge clk) disable iff (rst)
        (pwm_active[i] && polarity_r[i] && !drive_type_r[i]) |=> !led_pin_oe[i])
        else $error("non-inverted open drain pin not released");
      a_od_never_high: assert property (@(posedge clk) disable iff (rst)
        !drive_type_r[i] |=> !led_pin_out[i])
        else $error("open drain pin driven high");
      a_host_actuates: assert property (@(posedge clk) disable iff (rst)
        (!touch_link_r[i] && host_drive_r[i]) |=> act_r[i])
        else $error("host bit did not actuate unlinked channel");
      a_touch_actuates: assert property (@(posedge clk) disable iff (rst)
        (touch_link_r[i] && touch[i]) |=> act_r[i])
        else $error("touch did not actuate linked channel");
    end
  endgenerate

  // ****************************************
  // register checks
  // ****************************************
  a_mirror_follows: assert property (@(posedge clk) disable iff (rst)
    (reg_wr_en && reg_addr == lpd_pkg::ADDR_POLARITY && !polarity_mirror_block)
    |=> (duty_mirror_r == $past(reg_wdata[lpd_pkg::CH_N-1:0])))
    else $error("mirror not copied from polarity write");
  a_mirror_blocked: assert property (@(posedge clk) disable iff (rst)
    (reg_wr_en && reg_addr == lpd_pkg::ADDR_POLARITY && polarity_mirror_block)
    |=> $stable(duty_mirror_r))
    else $error("blocked mirror changed on polarity write");
  a_type_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr_en && reg_addr == lpd_pkg::ADDR_DRIVE_TYPE)
    |=> (drive_type_r == $past(reg_wdata[lpd_pkg::CH_N-1:0])))
    else $error("drive type write not stored");
  a_type_holds: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr_en && reg_addr == lpd_pkg::ADDR_DRIVE_TYPE) |=> $stable(drive_type_r))
    else $error("drive type changed without write");
  a_link_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr_en && reg_addr == lpd_pkg::ADDR_LINK)
    |=> (touch_link_r == $past(reg_wdata[lpd_pkg::CH_N-1:0])))
    else $error("link write not stored");
  a_pol_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr_en && reg_addr == lpd_pkg::ADDR_POLARITY)
    |=> (polarity_r == $past(reg_wdata[lpd_pkg::CH_N-1:0])))
    else $error("polarity write not stored");
  a_host_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr_en && reg_addr == lpd_pkg::ADDR_HOST_DRIVE)
    |=> (host_drive_r == $past(reg_wdata[lpd_pkg::CH_N-1:0])))
    else $error("host drive write not stored");
  a_mirror_write: assert property (@(posedge clk) disable iff (rst)
    (reg_wr_en && reg_addr == lpd_pkg::ADDR_MIRROR)
    |=> (duty_mirror_r == $past(reg_wdata[lpd_pkg::CH_N-1:0])))
    else $error("mirror write not stored");
  a_mirror_holds: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr_en && (reg_addr == lpd_pkg::ADDR_MIRROR
      || (reg_addr == lpd_pkg::ADDR_POLARITY && !polarity_mirror_block)))
    |=> $stable(duty_mirror_r))
    else $error("mirror changed without a write");
  a_rd_type: assert property (@(posedge clk) disable iff (rst)
    (reg_rd_en && reg_addr == lpd_pkg::ADDR_DRIVE_TYPE)
    |=> (reg_rdata == {lpd_pkg::RD_PAD, $past(drive_type_r)}))
    else $error("drive type read wrong");
  a_rd_link: assert property (@(posedge clk) disable iff (rst)
    (reg_rd_en && reg_addr == lpd_pkg::ADDR_LINK)
    |=> (reg_rdata == {lpd_pkg::RD_PAD, $past(touch_link_r)}))
    else $error("link read wrong");
  a_rd_unmapped: assert property (@(posedge clk) disable iff (rst)
    (reg_rd_en && reg_addr != lpd_pkg::ADDR_DRIVE_TYPE && reg_addr != lpd_pkg::ADDR_LINK
     && reg_addr != lpd_pkg::ADDR_POLARITY && reg_addr != lpd_pkg::ADDR_HOST_DRIVE
     && reg_addr != lpd_pkg::ADDR_MIRROR) |=> (reg_rdata == lpd_pkg::RD_RST))
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_upper_zero: assert property (@(posedge clk) disable iff (rst)
    reg_rd_en |=> (reg_rdata[7:lpd_pkg::CH_N] == lpd_pkg::RD_PAD))
    else $error("upper read bits not zero");
endmodule // lpd_led_pin_drive_control
`default_nettype wire

// ### lpd_led_model.sv
`default_nettype none
// ****************************************
// external leds with pull-up resistors
// ****************************************
module lpd_led_model (
  input  wire logic [lpd_pkg::CH_N-1:0] pin_out,
  input  wire logic [lpd_pkg::CH_N-1:0] pin_oe,
  output var  logic [lpd_pkg::CH_N-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // a released pin floats up through its resistor, never holds the last value
  always_comb begin
    for (int i = 0; i < lpd_pkg::CH_N; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
  end
endmodule // lpd_led_model
`default_nettype wire

// ### tb_led_pin_drive_control.sv
`default_nettype none
module tb_led_pin_drive_control;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = lpd_pkg::CH_N;
  logic                         clk = 1'b0;
  logic                         rst = 1'b1;
  logic [7:0]                   reg_addr = 8'h00;
  logic                         reg_wr_en = 1'b0;
  logic [7:0]                   reg_wdata = 8'h00;
  logic                         reg_rd_en = 1'b0;
  logic [7:0]                   reg_rdata;
  logic                         sense_input_1 = 1'b0;
  logic                         sense_input_2 = 1'b0;
  logic                         sense_input_3 = 1'b0;
  logic                         polarity_mirror_block = 1'b0;
  lpd_pkg::lpd_pct_t [N-1:0]    min_duty = '0;
  lpd_pkg::lpd_pct_t [N-1:0]    max_duty = '0;
  logic [N-1:0]                 beh_direct = '0;
  lpd_pkg::lpd_pct_t [N-1:0]    beh_level = '0;
  logic [N-1:0]                 led_actuated;
  logic [N-1:0]                 led_duty_mirror;
  logic [N-1:0]                 led_pin_out;
  logic [N-1:0]                 led_pin_oe;
  logic [N-1:0]                 pin_level;
  int                           n_mismatch = 0;
  int                           cmp_count = 0;
  logic [7:0]                   rd_v;
  logic [7:0]                   wv;
  logic [N-1:0]                 typ, pol, lnk, hst, act, lvl, oe_v;
  lpd_pkg::lpd_pct_t            exp_pct;
  logic [15:0]                  cnt [N];
  logic [7:0]                   addrs [6] = '{8'h71, 8'h72, 8'h79, 8'h73, 8'h74, 8'h75};

  always #2.5 clk = ~clk;

  lpd_led_pin_drive_control u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .sense_input_1(sense_input_1), .sense_input_2(sense_input_2),
    .sense_input_3(sense_input_3), .polarity_mirror_block(polarity_mirror_block),
    .min_duty(min_duty), .max_duty(max_duty), .beh_direct(beh_direct),
    .beh_level(beh_level), .led_actuated(led_actuated),
    .led_duty_mirror(led_duty_mirror), .led_pin_out(led_pin_out), .led_pin_oe(led_pin_oe)
  );

  lpd_led_model u_led (.pin_out(led_pin_out), .pin_oe(led_pin_oe), .pin_level(pin_level));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(30728));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(16'(led_pin_oe), 16'h0000, "pins released in reset");
    // mirror sits before polarity so its reset value is seen untouched
    foreach (addrs[i]) begin
      rd(addrs[i], rd_v);
      chk(16'(rd_v), 16'h0000, "reset value");
      wv = 8'($urandom);
      wr(addrs[i], wv);
      rd(addrs[i], rd_v);
      wv = (addrs[i] == 8'h75) ? 8'h00 : {5'h00, wv[2:0]};
      chk(16'(rd_v), 16'(wv), "readback");
    end
    for (int k = 0; k < 4; k++) begin
      polarity_mirror_block = k[1];
      wv = 8'($urandom);
      rd(8'h79, rd_v);
      wr(8'h73, wv);
      @(negedge clk);
      chk(16'(led_duty_mirror), 16'(k[1] ? rd_v[2:0] : wv[2:0]), "mirror copy");
    end
    // duty 0 never on, duty 100 always on; engine level held at 0 so a
    // direct channel and an engine-driven one show different pins
    max_duty = {N{7'h64}};
    beh_level = {N{7'h00}};
    for (int k = 0; k < 24; k++) begin
      {typ, pol, lnk, hst} = 12'($urandom);
      wr(8'h71, {5'h00, typ});
      wr(8'h72, {5'h00, lnk});
      wr(8'h73, {5'h00, pol});
      wr(8'h74, {5'h00, hst});
      wr(8'h79, 8'($urandom));
      {sense_input_3, sense_input_2, sense_input_1} = 3'($urandom);
      beh_direct = 3'($urandom);
      repeat (6) @(negedge clk);
      act = (lnk & {sense_input_3, sense_input_2, sense_input_1}) | (~lnk & hst);
      lvl = ~(pol ^ (act & beh_direct));
      oe_v = typ | ~lvl;
      chk(16'(led_actuated), 16'(act), "actuation");
      chk(16'(led_pin_oe), 16'(oe_v), "pin enable");
      chk(16'(led_pin_out), 16'(typ & lvl), "pin value");
      chk(16'(pin_level), 16'(lvl), "wire level");
    end
    // measured duty: push-pull, random polarity, host driven
    pol = 3'($urandom);
    wr(8'h71, 8'h07);
    wr(8'h72, 8'h00);
    wr(8'h73, {5'h00, pol});
    // third pass runs the engine level instead of the direct maximum
    for (int ph = 0; ph < 3; ph++) begin
      beh_direct = (ph == 2) ? 3'h0 : 3'h7;
      for (int c = 0; c < N; c++) begin
        min_duty[c] = 7'($urandom_range(1, 49));
        max_duty[c] = 7'($urandom_range(50, 99));
        beh_level[c] = 7'($urandom_range(1, 99));
        cnt[c] = 16'h0000;
      end
      wr(8'h74, (ph == 0) ? 8'h00 : 8'h07);
      // a full period first, in case duty is latched at period start
      repeat (100 * lpd_pkg::PWM_STEP_CYC + 6) @(negedge clk);
      repeat (100 * lpd_pkg::PWM_STEP_CYC) begin
        @(negedge clk);
        for (int c = 0; c < N; c++) begin
          if (pin_level[c] === pol[c]) begin
            cnt[c]++;
          end
        end
      end
      for (int c = 0; c < N; c++) begin
        exp_pct = (ph == 0) ? min_duty[c] : ((ph == 1) ? max_duty[c] : beh_level[c]);
        chk(cnt[c], 16'(exp_pct * lpd_pkg::PWM_STEP_CYC), "duty");
      end
    end
    tally_and_finish();
  end
endmodule // tb_led_pin_drive_control
`default_nettype wire
